//--- bae_pkg.sv
// Package with register map, field positions and opcodes of the exec block
package bae_pkg;
  // Register byte offsets on the Avalon-MM slave
  localparam logic [7:0] BAE_OFF_WREG = 8'h00;
  localparam logic [7:0] BAE_OFF_STATUS = 8'h04;
  localparam logic [7:0] BAE_OFF_BANK = 8'h08;
  localparam logic [7:0] BAE_OFF_INDEX = 8'h0C;
  localparam logic [7:0] BAE_OFF_CFG = 8'h10;
  localparam logic [7:0] BAE_OFF_INSTR = 8'h14;
  localparam logic [7:0] BAE_OFF_MADDR = 8'h18;
  localparam logic [7:0] BAE_OFF_MDATA = 8'h1C;
  // Status bit positions
  localparam int BAE_ST_C = 0;
  localparam int BAE_ST_DC = 1;
  localparam int BAE_ST_Z = 2;
  localparam int BAE_ST_OV = 3;
  localparam int BAE_ST_N = 4;
  // Config bit position: extended instruction set enable
  localparam int BAE_CFG_EXT = 0;
  // Reset values
  localparam logic [7:0] BAE_RST_WREG = 8'h00;
  localparam logic [3:0] BAE_RST_BANK = 4'h0;
  localparam logic [11:0] BAE_RST_INDEX = 12'h000;
  localparam logic [15:0] BAE_RST_INSTR = 16'h0000;
  // Opcodes
  localparam logic [15:0] BAE_OP_DAW = 16'h0007;
  localparam logic [5:0] BAE_OP_FILE_DECREMENT_OP_HI = 6'h01;
  localparam int BAE_FILE_DECREMENT_OP_D = 9;
  localparam int BAE_FILE_DECREMENT_OP_A = 8;
  // Addressing and BCD adjust constants
  localparam logic [7:0] BAE_ACC_LIMIT = 8'h5F;
  localparam logic [3:0] BAE_ACC_HI_BANK = 4'hF;
  localparam logic [3:0] BAE_ACC_LO_BANK = 4'h0;
  localparam logic [3:0] BAE_BCD_MAX = 4'h9;
  localparam logic [3:0] BAE_BCD_FIX = 4'h6;
  localparam int BAE_MEM_DEPTH = 4096;
  // Arithmetic flags carried together
  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } bae_flags_t;
endpackage

//--- bae_alu.sv
// Combinational arithmetic for decimal adjust and file decrement
`timescale 1ns/1ps
module bae_alu
  import bae_pkg::*;
(
  // Operands
  input wire logic [7:0] acc,
  input wire logic [7:0] fval,
  input wire bae_pkg::bae_flags_t flags_in,
  // Decimal adjust results
  output logic [7:0] daw_res,
  output bae_pkg::bae_flags_t daw_flags,
  // Decrement results
  output logic [7:0] dec_res,
  output bae_pkg::bae_flags_t dec_flags
);
  // Low-adjusted sum, ninth bit is carry out
  logic [8:0] lo_sum;
  // Fully adjusted sum
  logic [8:0] hi_sum;

  // Decimal adjust of the accumulator
  always_comb
  begin
    lo_sum = {1'b0, acc};
    // (RQ1) low nibble fix
    if ((acc[3:0] > BAE_BCD_MAX) || flags_in.dc)
    begin
      lo_sum = {1'b0, acc} + {5'h00, BAE_BCD_FIX};
    end
    hi_sum = lo_sum;
    // (RQ2) high nibble fix
    if ((lo_sum[7:4] > BAE_BCD_MAX) || flags_in.c || lo_sum[8])
    begin
      hi_sum = lo_sum + {1'b0, BAE_BCD_FIX, 4'h0};
    end
    // (RQ3) whole byte result
    daw_res = hi_sum[7:0];
    daw_flags = flags_in;
    daw_flags.c = flags_in.c | lo_sum[8] | hi_sum[8];
  end

  // Decrement and subtract-one flags
  always_comb
  begin
    dec_res = fval - 8'h01;
    // (RQ8) subtract-one flags
    dec_flags.c = (fval != 8'h00);
    dec_flags.dc = (fval[3:0] != 4'h0);
    dec_flags.n = dec_res[7];
    dec_flags.ov = (fval == 8'h80);
    dec_flags.z = (dec_res == 8'h00);
  end
endmodule // bae_alu

//--- bae_exec.sv
// Exec datapath for decimal adjust and file decrement, Avalon-MM slave
//
// Operation
// (RQ1) Low nibble over nine or DC: add six
// (RQ2) High nibble over nine or C: add six
// (RQ3) Adjust whole accumulator into packed BCD
// (RQ4) Decrement file; d zero writes accumulator
// (RQ5) d one writes result back to file
// (RQ6) a zero access bank, one bank register
// (RQ7) Extended, a zero, f<=95: indexed offset
// (RQ8) Decrement sets C, DC, N, OV, Z
`timescale 1ns/1ps
module bae_exec
  import bae_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Avalon-MM slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest
);
  import bae_pkg::*;

  // Accumulator
  logic [7:0] wreg_q;
  // Arithmetic flags
  bae_flags_t flags_q;
  // General RAM bank select
  logic [3:0] bank_q;
  // Index base for literal offset addressing
  logic [11:0] index_q;
  // Extended instruction set enable
  logic ext_q;
  // Last instruction issued
  logic [15:0] instr_q;
  // Bus-side memory pointer
  logic [11:0] maddr_q;
  // Answer phase of a bus access
  logic ack_q;
  // Registered read data
  logic [31:0] rdata_q;
  // Data memory
  logic [7:0] mem [BAE_MEM_DEPTH];
  // Decode of the word being written
  logic [15:0] op;
  logic is_daw;
  logic is_file_decrement_op;
  logic [11:0] eff_addr;
  logic [7:0] fval;
  logic [7:0] daw_res;
  logic [7:0] dec_res;
  bae_flags_t daw_flags;
  bae_flags_t dec_flags;
  // Commit strobes
  logic wr_go;
  logic exec_go;

  // Merge byte lanes 0 and 1 into a 16-bit value
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
    input logic [15:0] nw, input logic [3:0] be);
    lane_merge = old;
    if (be[0])
    begin
      lane_merge[7:0] = nw[7:0];
    end
    if (be[1])
    begin
      lane_merge[15:8] = nw[15:8];
    end
  endfunction

  // Resolve an operand address from f, a, bank, index and mode
  function automatic logic [11:0] resolve(input logic [7:0] f,
    input logic a, input logic [3:0] bank, input logic [11:0] idx,
    input logic ext);
    if (a)
    begin
      // Bank register picks the general RAM bank
      resolve = {bank, f};
    end
    else if (ext && (f <= BAE_ACC_LIMIT))
    begin
      // Literal offset from the index base
      resolve = idx + {4'h0, f};
    end
    else if (f <= BAE_ACC_LIMIT)
    begin
      // Lower part of the access bank
      resolve = {BAE_ACC_LO_BANK, f};
    end
    else
    begin
      // Upper part of the access bank
      resolve = {BAE_ACC_HI_BANK, f};
    end
  endfunction

  // Bus handshake: one wait cycle, then the answer
  assign waitrequest = (read | write) & ~ack_q;
  assign readdata = rdata_q;
  assign wr_go = write & ack_q;
  assign exec_go = wr_go && (address == BAE_OFF_INSTR);

  // Instruction decode from the written word
  assign op = lane_merge(16'h0000, writedata[15:0], byteenable);
  assign is_daw = exec_go && (op == BAE_OP_DAW);
  assign is_file_decrement_op = exec_go && (op[15:10] == BAE_OP_FILE_DECREMENT_OP_HI);
  // (RQ6) bank or access
  // (RQ7) indexed mode
  assign eff_addr = resolve(op[7:0], op[BAE_FILE_DECREMENT_OP_A], bank_q, index_q,
    ext_q);
  assign fval = mem[eff_addr];

  // Shared arithmetic
  bae_alu u_alu (
    .acc(wreg_q),
    .fval(fval),
    .flags_in(flags_q),
    .daw_res(daw_res),
    .daw_flags(daw_flags),
    .dec_res(dec_res),
    .dec_flags(dec_flags)
  );

  // Answer phase toggles after each wait cycle
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= (read | write) & ~ack_q;
    end
  end

  // Read data captured during the wait cycle
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rdata_q <= 32'h00000000;
    end
    else if (read && !ack_q)
    begin
      unique case (address)
        BAE_OFF_WREG: rdata_q <= {24'h000000, wreg_q};
        BAE_OFF_STATUS: rdata_q <= {27'h0000000, flags_q};
        BAE_OFF_BANK: rdata_q <= {28'h0000000, bank_q};
        BAE_OFF_INDEX: rdata_q <= {20'h00000, index_q};
        BAE_OFF_CFG: rdata_q <= {31'h00000000, ext_q};
        BAE_OFF_INSTR: rdata_q <= {16'h0000, instr_q};
        BAE_OFF_MADDR: rdata_q <= {20'h00000, maddr_q};
        BAE_OFF_MDATA: rdata_q <= {24'h000000, mem[maddr_q]};
        // Unmapped reads return zero
        default: rdata_q <= 32'h00000000;
      endcase
    end
  end

  // Accumulator: bus write, adjust or decrement to W
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wreg_q <= BAE_RST_WREG;
    end
    else if (is_daw)
    begin
      // (RQ3) adjusted accumulator
      wreg_q <= daw_res;
    end
    else if (is_file_decrement_op && !op[BAE_FILE_DECREMENT_OP_D])
    begin
      // (RQ4) result into W
      wreg_q <= dec_res;
    end
    else if (wr_go && (address == BAE_OFF_WREG) && byteenable[0])
    begin
      // Software load
      wreg_q <= writedata[7:0];
    end
  end

  // Flags: instruction results or software load
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      flags_q <= '0;
    end
    else if (is_daw)
    begin
      // (RQ2) carry set
      flags_q <= daw_flags;
    end
    else if (is_file_decrement_op)
    begin
      // (RQ8) decrement flags
      flags_q <= dec_flags;
    end
    else if (wr_go && (address == BAE_OFF_STATUS) && byteenable[0])
    begin
      // Software load
      flags_q <= writedata[4:0];
    end
  end

  // Configuration registers written by software
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      bank_q <= BAE_RST_BANK;
      index_q <= BAE_RST_INDEX;
      ext_q <= 1'b0;
      maddr_q <= 12'h000;
    end
    else if (wr_go)
    begin
      if ((address == BAE_OFF_BANK) && byteenable[0])
      begin
        bank_q <= writedata[3:0];
      end
      if (address == BAE_OFF_INDEX)
      begin
        index_q <= lane_merge({4'h0, index_q}, writedata[15:0],
          byteenable)[11:0];
      end
      if ((address == BAE_OFF_CFG) && byteenable[0])
      begin
        ext_q <= writedata[BAE_CFG_EXT];
      end
      if (address == BAE_OFF_MADDR)
      begin
        maddr_q <= lane_merge({4'h0, maddr_q}, writedata[15:0],
          byteenable)[11:0];
      end
    end
  end

  // Last issued opcode, readable back
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      instr_q <= BAE_RST_INSTR;
    end
    else if (exec_go)
    begin
      instr_q <= op;
    end
  end

  // Data memory: decrement write-back or software store
  always_ff @(posedge clk)
  begin
    if (is_file_decrement_op && op[BAE_FILE_DECREMENT_OP_D])
    begin
      // (RQ5) result back to file
      mem[eff_addr] <= dec_res;
    end
    else if (wr_go && (address == BAE_OFF_MDATA) && byteenable[0])
    begin
      mem[maddr_q] <= writedata[7:0];
    end
  end
endmodule // bae_exec

//--- bae_exec_monitor.sv
// Bus timing and read-back checker for the exec block
`timescale 1ns/1ps
module bae_exec_monitor
  import bae_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Avalon-MM slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Request still waiting
  sequence s_wait;
    (read || write) && waitrequest;
  endsequence
  // Request answered
  sequence s_ack;
    (read || write) && !waitrequest;
  endsequence
  AST_FIRST_WAIT: assert property ($rose(read || write) |-> waitrequest)
    else $error("no wait cycle on new request");
  AST_ACK_NEXT: assert property (s_wait ##1 (read || write) |-> !waitrequest)
    else $error("answer not one cycle after request");
  AST_ONE_LOW: assert property (s_ack ##1 (read || write) |-> waitrequest)
    else $error("answer held past one cycle");
  AST_IDLE: assert property (!(read || write) |-> !waitrequest)
    else $error("wait raised with no request");
  AST_UNMAPPED: assert property (read && !waitrequest && address == 8'h20
    |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  AST_STATUS_RSV: assert property (read && !waitrequest
    && address == BAE_OFF_STATUS |-> readdata[31:5] == 27'h0)
    else $error("status reserved bits set");
  AST_W_RSV: assert property (read && !waitrequest && address == BAE_OFF_WREG
    |-> readdata[31:8] == 24'h0)
    else $error("accumulator reserved bits set");
  AST_RD_HOLD: assert property (!read ##1 !read |-> $stable(readdata))
    else $error("read data moved without a read");
endmodule // bae_exec_monitor

bind bae_exec bae_exec_monitor u_mon (.clk, .srst, .address, .read, .write,
  .byteenable, .writedata, .readdata, .waitrequest);

//--- bae_exec_bench.sv
// Self-checking bench for the decimal adjust and decrement exec block
`timescale 1ns/1ps
module bae_exec_bench;
  import bae_pkg::*;
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic [7:0] address = 8'h00;
  logic read = 1'h0;
  logic write = 1'h0;
  logic [3:0] byteenable = 4'h0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [31:0] rv;
  // Clock, 8 ns period
  always #4 clk = ~clk;
  bae_exec u_bae_exec (.clk, .srst, .address, .read, .write, .byteenable,
    .writedata, .readdata, .waitrequest);
  // Hang guard
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      errors++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One access, held until waitrequest is seen low
  task automatic bus(input logic rw, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    byteenable <= 4'hF;
    write <= rw;
    read <= !rw;
    do @(negedge clk); while (waitrequest !== 1'h0);
    rv = readdata;
    @(posedge clk);
    write <= 1'h0;
    read <= 1'h0;
  endtask
  // Reset values and unmapped place
  task automatic t_reset();
    logic [7:0] offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20};
    bus(1'h1, 8'h20, 32'hFF);
    foreach (offs[i])
    begin
      bus(1'h0, offs[i], 32'h0);
      chk(rv, 32'h0);
    end
    $display("test reset done");
  endtask
  // Expected carry and accumulator after an adjust
  function automatic logic [8:0] daw_exp(input logic [7:0] w,
    input logic c, input logic dc);
    logic [8:0] s;
    logic f;
    s = {1'h0, w};
    if (w[3:0] > 4'h9 || dc)
      s = s + 9'h006;
    f = s[7:4] > 4'h9 || c || s[8];
    if (f)
      s = s + 9'h060;
    return {c | f | s[8], s[7:0]};
  endfunction
  task automatic t_daw(input logic [7:0] w, input logic [4:0] st);
    logic [8:0] e;
    e = daw_exp(w, st[0], st[1]);
    bus(1'h1, BAE_OFF_WREG, {24'h0, w});
    bus(1'h1, BAE_OFF_STATUS, {27'h0, st});
    bus(1'h1, BAE_OFF_INSTR, {16'h0, BAE_OP_DAW});
    bus(1'h0, BAE_OFF_WREG, 32'h0);
    chk(rv, {24'h0, e[7:0]});
    bus(1'h0, BAE_OFF_STATUS, 32'h0);
    chk(rv, {27'h0, st[4:1], e[8]});
    $display("test adjust %h done", w);
  endtask
  task automatic t_dec(input logic a, input logic d, input logic [7:0] f,
    input logic ext, input logic [11:0] adr, input logic [7:0] v);
    logic [7:0] r;
    r = v - 8'h01;
    bus(1'h1, BAE_OFF_CFG, {31'h0, ext});
    bus(1'h1, BAE_OFF_BANK, 32'h3);
    bus(1'h1, BAE_OFF_INDEX, 32'h123);
    bus(1'h1, BAE_OFF_MADDR, {20'h0, adr});
    bus(1'h1, BAE_OFF_MDATA, {24'h0, v});
    bus(1'h1, BAE_OFF_WREG, 32'h5A);
    bus(1'h1, BAE_OFF_INSTR, {16'h0, BAE_OP_FILE_DECREMENT_OP_HI, d, a, f});
    bus(1'h0, BAE_OFF_WREG, 32'h0);
    chk(rv, {24'h0, d ? 8'h5A : r});
    bus(1'h0, BAE_OFF_MDATA, 32'h0);
    chk(rv, {24'h0, d ? r : v});
    bus(1'h0, BAE_OFF_STATUS, 32'h0);
    chk(rv, {27'h0, r[7], v == 8'h80, r == 8'h0, v[3:0] != 4'h0,
      v != 8'h0});
    $display("test decrement %h done", f);
  endtask
  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    srst <= 1'h0;
    t_reset();
    t_daw(8'hA5, 5'h00);
    t_daw(8'hCE, 5'h00);
    t_daw(8'h19, 5'h02);
    t_daw(8'h99, 5'h01);
    t_daw(8'h0A, 5'h1C);
    t_dec(1'h1, 1'h0, 8'h45, 1'h0, 12'h345, 8'h80);
    t_dec(1'h1, 1'h1, 8'h45, 1'h0, 12'h345, 8'h01);
    t_dec(1'h0, 1'h1, 8'h10, 1'h0, 12'h010, 8'h00);
    t_dec(1'h0, 1'h0, 8'h80, 1'h1, 12'hF80, 8'h10);
    t_dec(1'h0, 1'h1, 8'h5F, 1'h1, 12'h182, 8'h33);
    t_dec(1'h0, 1'h1, 8'h60, 1'h1, 12'hF60, 8'h33);
    t_dec(1'h0, 1'h1, 8'h00, 1'h1, 12'h123, 8'h3F);
    conclude();
  end
endmodule // bae_exec_bench
